// *** rtl/t1_tx_signalling_slot_ctrl.sv ***
// Per-channel transmit signalling insertion and per-slot control for a T1 framer.
// Assumes the framer gives one slot strobe per DS1 slot with slot and superframe
// frame numbers, and that the microport is synchronous to clock.
`timescale 1ns/1ps

// Summary of operation
// - Signalling words sit at 0x10-0x1F page 5 (ch 1-16), 0x10-0x17 page 6.
// - Source select high takes the channel's signalling from its host register.
// - Source select low takes signalling from the channel's serial input slot.
// - Bit A goes in bit 8 of frame 6, D4 and ESF.
// - Bit B goes in bit 8 of frame 12, D4 and ESF.
// - Bit C goes in bit 8 of frame 18, ESF only.
// - Bit D goes in bit 8 of frame 24, ESF only.
// - Nibble select one uses serial bits 7-4, zero uses bits 3-0.
// - ESF serial signalling sends the four nibble bits in frames 6,12,18,24.
// - D4 serial signalling sends A in frame 6, B in 12; C, D ignored.
// - Slot control words at 0x10-0x1F page 7 (slots 1-16), 0x10-0x17 page 8.
// - Message bit sends the message register instead of backplane data.
// - Inversion bit inverts backplane data to line and line data to backplane.
// - Remote loop sends received slot back out, still shown on backplane.
// - Local loop returns transmit slot to receive side, still transmitted.
// - Transmit test sends milliwatt or PRBS-15 per pattern select.
// - Receive test injects milliwatt on backplane or feeds PRBS detector.
// - Clear-channel bit suppresses robbed-bit signalling in that slot.
module t1_tx_signalling_slot_ctrl (
   input wire logic clock, // 200 MHz system clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire t1_sig_pkg::host_req_t host_req, // Microport request
   output logic [7:0] host_rdata, // Read data, one cycle after rd
   input wire logic esf_mode, // 1 = ESF 24 frames, 0 = D4 12 frames
   input wire logic serial_nibble_sel, // Serial signalling nibble select
   input wire logic test_pattern_sel, // 1 = milliwatt, 0 = PRBS
   input wire t1_sig_pkg::slot_time_t slot_time, // Slot strobe with slot and frame
   input wire logic [7:0] serial_sig_in, // Serial signalling byte of this slot
   input wire logic [7:0] line_rx_data, // Received DS1 slot byte
   input wire logic backplane_tx_valid, // Backplane transmit byte valid
   output logic backplane_tx_ready, // FIFO has room
   input wire logic [7:0] backplane_tx_in, // Backplane transmit byte
   output logic [7:0] line_tx_data, // DS1 transmit slot byte
   output logic line_tx_valid, // Pulse with line_tx_data
   output logic [7:0] backplane_rx_out, // Backplane receive slot byte
   output logic backplane_rx_valid, // Pulse with backplane_rx_out
   output logic [7:0] prbs_det_data, // Slot byte for PRBS detector
   output logic prbs_det_valid, // Pulse with prbs_det_data
   output logic tx_underrun // Pulse when FIFO empty at a slot
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register storage and decode
   logic [3:0] sig_reg [t1_sig_pkg::NUM_CH];
   t1_sig_pkg::slot_ctrl_t ctrl_reg [t1_sig_pkg::NUM_CH];
   logic [7:0] msg_reg;
   logic [3:0] sig_latch [t1_sig_pkg::NUM_CH];
   logic addr_in_block;
   logic page_is_hi;
   logic [4:0] reg_ch;
   logic ch_ok;
   logic sig_hit;
   logic ctrl_hit;
   logic msg_hit;
   logic [7:0] next_rdata;

   assign page_is_hi = host_req.page == t1_sig_pkg::SIG_PAGE_HI
                       || host_req.page == t1_sig_pkg::CTRL_PAGE_HI;
   assign addr_in_block = host_req.addr[4] == t1_sig_pkg::CH_BASE_ADDR[4];
   assign reg_ch = page_is_hi ? t1_sig_pkg::HI_PAGE_FIRST_CH + {2'b00, host_req.addr[2:0]}
                              : {1'b0, host_req.addr[3:0]};
   assign ch_ok = addr_in_block && !(page_is_hi && host_req.addr[3]);
   assign sig_hit = ch_ok && (host_req.page == t1_sig_pkg::SIG_PAGE_LO
                              || host_req.page == t1_sig_pkg::SIG_PAGE_HI);
   assign ctrl_hit = ch_ok && (host_req.page == t1_sig_pkg::CTRL_PAGE_LO
                               || host_req.page == t1_sig_pkg::CTRL_PAGE_HI);
   assign msg_hit = host_req.page == t1_sig_pkg::MSG_PAGE && host_req.addr == t1_sig_pkg::MSG_ADDR;

   always_comb
   begin
      next_rdata = 8'h00;
      if (sig_hit)
         next_rdata = {4'h0, sig_reg[reg_ch]};
      else if (ctrl_hit)
         next_rdata = ctrl_reg[reg_ch];
      else if (msg_hit)
         next_rdata = msg_reg;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         host_rdata <= 8'h00;
      else if (host_req.cs && host_req.rd)
         host_rdata <= next_rdata;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         msg_reg <= t1_sig_pkg::MSG_RESET;
      else if (host_req.cs && host_req.wr && msg_hit)
         msg_reg <= host_req.wdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel registers and superframe signalling latch
   logic [3:0] serial_nibble;

   assign serial_nibble = serial_nibble_sel ? serial_sig_in[7:4] : serial_sig_in[3:0];

   generate
      for (genvar ch = 0; ch < t1_sig_pkg::NUM_CH; ch++)
      begin : g_ch
         logic wr_this;
         logic sf_start;
         assign wr_this = host_req.cs && host_req.wr && reg_ch == 5'(ch);
         assign sf_start = slot_time.strobe && slot_time.slot == 5'(ch)
                           && slot_time.frame == t1_sig_pkg::FRAME_SF_START;

         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               sig_reg[ch] <= t1_sig_pkg::SIG_RESET;
            else if (wr_this && sig_hit)
               sig_reg[ch] <= host_req.wdata[3:0];
         end

         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               ctrl_reg[ch] <= t1_sig_pkg::CTRL_RESET;
            else if (wr_this && ctrl_hit)
               ctrl_reg[ch] <= host_req.wdata;
         end

         // Sampled only at superframe start so A..D of one superframe never mix two
         // host writes; a change takes effect from the next superframe.
         // once per superframe
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
               sig_latch[ch] <= t1_sig_pkg::SIG_RESET;
            else if (sf_start)
               sig_latch[ch] <= ctrl_reg[ch].sig_source_sel ? sig_reg[ch] : serial_nibble;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Slot data path
   t1_sig_pkg::slot_ctrl_t cur_ctrl;
   logic [3:0] cur_sig;
   logic [4:0] sig_slot;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic [7:0] mw_byte;
   logic [7:0] prbs_byte;
   logic [7:0] bp_byte;
   logic [7:0] tx_base;
   logic [7:0] next_tx;
   logic [7:0] rx_base;
   logic [7:0] next_rx;
   logic rob_frame;
   logic rob_bit;
   logic frame_start;
   logic prbs_use;

   assign sig_slot = slot_time.slot < 5'(t1_sig_pkg::NUM_CH) ? slot_time.slot : 5'h00;
   assign cur_ctrl = ctrl_reg[sig_slot];
   assign cur_sig = sig_latch[sig_slot];
   assign frame_start = slot_time.strobe && slot_time.slot == 5'h00;
   assign prbs_use = slot_time.strobe && !test_pattern_sel
                     && cur_ctrl.tx_test_en && !cur_ctrl.remote_slot_loop;

   bp_fifo #(
      .WIDTH(t1_sig_pkg::BYTE_W),
      .DEPTH(t1_sig_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(backplane_tx_valid),
      .in_ready(backplane_tx_ready),
      .in_data(backplane_tx_in),
      .out_valid(fifo_valid),
      .out_ready(slot_time.strobe),
      .out_data(fifo_data)
   );

   test_pattern_gen u_pattern (
      .clock(clock),
      .rst_n(rst_n),
      .mw_step(frame_start),
      .prbs_step(prbs_use),
      .mw_byte(mw_byte),
      .prbs_byte(prbs_byte)
   );

   // Backplane byte is consumed every slot, used or not, to keep slot alignment
   assign bp_byte = fifo_valid ? fifo_data : t1_sig_pkg::IDLE_BYTE;

   // Robbed-bit position: D4 uses A and B only, ESF all four
   always_comb
   begin
      rob_frame = 1'b0;
      rob_bit = 1'b0;
      case (slot_time.frame)
         t1_sig_pkg::FRAME_A:
         begin
            rob_frame = 1'b1;
            rob_bit = cur_sig[3];
         end
         t1_sig_pkg::FRAME_B:
         begin
            rob_frame = 1'b1;
            rob_bit = cur_sig[2];
         end
         t1_sig_pkg::FRAME_C:
         begin
            rob_frame = esf_mode;
            rob_bit = cur_sig[1];
         end
         t1_sig_pkg::FRAME_D:
         begin
            rob_frame = esf_mode;
            rob_bit = cur_sig[0];
         end
         default:
         begin
            rob_frame = 1'b0;
            rob_bit = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      if (cur_ctrl.remote_slot_loop)
         tx_base = line_rx_data;
      else if (cur_ctrl.tx_test_en)
         tx_base = test_pattern_sel ? mw_byte : prbs_byte;
      else if (cur_ctrl.msg_substitute)
         tx_base = msg_reg;
      else
         tx_base = bp_byte ^ {8{cur_ctrl.per_slot_invert}};
      if (rob_frame && !cur_ctrl.no_robbed_bit)
         next_tx = {tx_base[7:1], rob_bit};
      else
         next_tx = tx_base;
   end

   always_comb
   begin
      rx_base = cur_ctrl.local_slot_loop ? next_tx : line_rx_data;
      if (cur_ctrl.rx_test_en && test_pattern_sel)
         next_rx = mw_byte;
      else
         next_rx = rx_base ^ {8{cur_ctrl.per_slot_invert}};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_tx_data <= 8'h00;
         backplane_rx_out <= 8'h00;
      end
      else if (slot_time.strobe)
      begin
         line_tx_data <= next_tx;
         backplane_rx_out <= next_rx;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_tx_valid <= 1'b0;
         backplane_rx_valid <= 1'b0;
         tx_underrun <= 1'b0;
      end
      else
      begin
         line_tx_valid <= slot_time.strobe;
         backplane_rx_valid <= slot_time.strobe;
         tx_underrun <= slot_time.strobe && !fifo_valid;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prbs_det_data <= 8'h00;
         prbs_det_valid <= 1'b0;
      end
      else
      begin
         prbs_det_valid <= slot_time.strobe && cur_ctrl.rx_test_en && !test_pattern_sel;
         if (slot_time.strobe)
            prbs_det_data <= line_rx_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
      host_req.cs && host_req.rd && host_req.page == t1_sig_pkg::CTRL_PAGE_HI
      && host_req.addr[4:3] == 2'b11 |=> host_rdata == 8'h00)
      else $error("unmapped address read nonzero");

   a_sig_a_insert: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && slot_time.frame == t1_sig_pkg::FRAME_A && !cur_ctrl.no_robbed_bit
      |=> line_tx_data[0] == $past(cur_sig[3]))
      else $error("signalling A missing in frame 6");

   a_sig_b_insert: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && slot_time.frame == t1_sig_pkg::FRAME_B && !cur_ctrl.no_robbed_bit
      |=> line_tx_data[0] == $past(cur_sig[2]))
      else $error("signalling B missing in frame 12");

   a_sig_c_esf: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && esf_mode && slot_time.frame == t1_sig_pkg::FRAME_C
      && !cur_ctrl.no_robbed_bit |=> line_tx_data[0] == $past(cur_sig[1]))
      else $error("signalling C missing in frame 18");

   a_sig_d_esf: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && esf_mode && slot_time.frame == t1_sig_pkg::FRAME_D
      && !cur_ctrl.no_robbed_bit |=> line_tx_data[0] == $past(cur_sig[0]))
      else $error("signalling D missing in frame 24");

   a_msg_slot: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && cur_ctrl.msg_substitute && !cur_ctrl.remote_slot_loop
      && !cur_ctrl.tx_test_en && slot_time.frame == t1_sig_pkg::FRAME_SF_START
      ##1 line_tx_valid |-> line_tx_data == msg_reg)
      else $error("message register not sent");

   a_remote_loop: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && cur_ctrl.remote_slot_loop && cur_ctrl.no_robbed_bit
      |=> line_tx_data == $past(line_rx_data) && backplane_rx_valid)
      else $error("remote loop data wrong");

   a_local_loop: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && cur_ctrl.local_slot_loop && !cur_ctrl.per_slot_invert
      && !cur_ctrl.rx_test_en |=> backplane_rx_out == line_tx_data)
      else $error("local loop data wrong");

   a_sig_host_src: assert property (@(posedge clock) disable iff (!rst_n)
      slot_time.strobe && slot_time.frame == t1_sig_pkg::FRAME_SF_START
      && slot_time.slot == 5'h00 && ctrl_reg[0].sig_source_sel |=> sig_latch[0] == $past(sig_reg[0]))
      else $error("host signalling not latched");
endmodule

// *** rtl/t1_sig_pkg.sv ***
// Shared constants and carrier types for the T1 transmit signalling and slot control block.
// Assumes one 200 MHz clock; framer timing and the microport are synchronous to it.
package t1_sig_pkg;
   localparam int NUM_CH = 24;
   localparam int HI_PAGE_CHANS = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int BYTE_W = 8;
   // Microport map
   localparam logic [3:0] MSG_PAGE = 4'h1;
   localparam logic [4:0] MSG_ADDR = 5'h18;
   localparam logic [3:0] SIG_PAGE_LO = 4'h5;
   localparam logic [3:0] SIG_PAGE_HI = 4'h6;
   localparam logic [3:0] CTRL_PAGE_LO = 4'h7;
   localparam logic [3:0] CTRL_PAGE_HI = 4'h8;
   localparam logic [4:0] CH_BASE_ADDR = 5'h10;
   localparam logic [4:0] HI_PAGE_FIRST_CH = 5'h10;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [3:0] SIG_RESET = 4'h0;
   localparam logic [7:0] MSG_RESET = 8'h00;
   localparam logic [14:0] PRBS_SEED = 15'h7FFF;
   // Superframe start and the superframe frames (counted from 0) that carry robbed bits
   localparam logic [4:0] FRAME_SF_START = 5'h00;
   localparam logic [4:0] FRAME_A = 5'h05;
   localparam logic [4:0] FRAME_B = 5'h0B;
   localparam logic [4:0] FRAME_C = 5'h11;
   localparam logic [4:0] FRAME_D = 5'h17;
   // Sent when the backplane FIFO has nothing for the slot
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   // Digital milliwatt, mu-law, eight samples per cycle
   localparam logic [2:0] MW_LAST = 3'h7;
   localparam logic [63:0] MW_TABLE = 64'h1E0B0B1E9E8B8B9E;

   typedef struct packed {
      logic msg_substitute;
      logic per_slot_invert;
      logic remote_slot_loop;
      logic local_slot_loop;
      logic tx_test_en;
      logic rx_test_en;
      logic sig_source_sel;
      logic no_robbed_bit;
   } slot_ctrl_t;

   typedef struct packed {
      logic strobe;
      logic [4:0] slot;
      logic [4:0] frame;
   } slot_time_t;

   typedef struct packed {
      logic cs;
      logic wr;
      logic rd;
      logic [3:0] page;
      logic [4:0] addr;
      logic [7:0] wdata;
   } host_req_t;
endpackage

// *** rtl/bp_fifo.sv ***
// Synchronous FIFO for backplane transmit bytes.
// Assumes both sides on the same clock; no pass-through when empty.
`timescale 1ns/1ps
module bp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)(
   input wire logic clock, // System clock
   input wire logic rst_n, // Asynchronous reset
   input wire logic in_valid, // Write request
   output logic in_ready, // Not full
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Not empty
   input wire logic out_ready, // Read accept
   output logic [WIDTH-1:0] out_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_wr;
   logic do_rd;

   assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always_ff @(posedge clock)
   begin
      if (do_wr)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

// *** rtl/test_pattern_gen.sv ***
// Test pattern source: digital milliwatt and PRBS 2^15-1, one byte per step.
// Assumes step pulses come from the slot logic on the same clock.
`timescale 1ns/1ps
module test_pattern_gen (
   input wire logic clock, // System clock
   input wire logic rst_n, // Asynchronous reset
   input wire logic mw_step, // Advance milliwatt phase
   input wire logic prbs_step, // Advance PRBS by one byte
   output logic [7:0] mw_byte, // Current milliwatt sample
   output logic [7:0] prbs_byte // Current PRBS byte
);
   logic [2:0] mw_phase;
   logic [14:0] lfsr;
   logic [14:0] next_lfsr;

   assign mw_byte = t1_sig_pkg::MW_TABLE[63 - 8 * mw_phase -: 8];
   assign prbs_byte = lfsr[14:7];

   // x^15 + x^14 + 1, eight shifts per byte
   always_comb
   begin
      next_lfsr = lfsr;
      for (int i = 0; i < 8; i++)
         next_lfsr = {next_lfsr[13:0], next_lfsr[14] ^ next_lfsr[13]};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mw_phase <= 3'h0;
      else if (mw_step)
         mw_phase <= (mw_phase == t1_sig_pkg::MW_LAST) ? 3'h0 : mw_phase + 3'h1;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         lfsr <= t1_sig_pkg::PRBS_SEED;
      else if (prbs_step)
         lfsr <= next_lfsr;
   end
endmodule

// *** verification/framer_model.sv ***
// Framer and line stream model: slot strobes, serial signalling and line bytes.
// Assumes the bench raises run only after the host side has been configured.
`timescale 1ns/1ps
module framer_model (
   input wire logic clock, // System clock
   input wire logic run, // Runs while high; low holds slot 0, frame 0 for a restart
   input wire logic esf_mode, // Superframe length
   output t1_sig_pkg::slot_time_t slot_time, // Strobe, slot and frame
   output logic [7:0] serial_sig_in, // Serial signalling byte
   output logic [7:0] line_rx_data // Received line byte
);
   logic [1:0] gap = 2'h1;
   logic [4:0] cslot = 5'h00;
   logic [4:0] cframe = 5'h00;

   initial
   begin
      slot_time = '0;
      serial_sig_in = 8'h00;
      line_rx_data = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data is only valid with the strobe, so it flips on every cycle without a strobe to expose misuse
   // one byte per slot
   always @(negedge clock)
   begin
      if (!run)
      begin
         slot_time.strobe <= 1'b0;
         gap <= 2'h1;
         cslot <= 5'h00;
         cframe <= 5'h00;
      end
      else if (gap != 2'h0)
      begin
         slot_time.strobe <= 1'b0;
         gap <= gap - 2'h1;
      end
      else
      begin
         gap <= 2'($urandom_range(3, 1));
         slot_time <= '{strobe: 1'b1, slot: cslot, frame: cframe};
         cslot <= (cslot == 5'h17) ? 5'h00 : cslot + 5'h01;
         if (cslot == 5'h17)
            cframe <= (cframe == (esf_mode ? 5'h17 : 5'h0B)) ? 5'h00 : cframe + 5'h01;
      end
      serial_sig_in <= (run && gap == 2'h0) ? 8'($urandom) : ~serial_sig_in;
      line_rx_data <= (run && gap == 2'h0) ? 8'($urandom) : ~line_rx_data;
   end
endmodule

// *** verification/test_t1_tx_signalling_slot_ctrl.sv ***
// Self-checking bench for the T1 transmit signalling and slot control block.
// Assumes the framer model drives slot timing; the bench drives host, FIFO and modes.
`timescale 1ns/1ps
module test_t1_tx_signalling_slot_ctrl;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   t1_sig_pkg::host_req_t host_req = '0;
   logic esf_mode = 1'b0, serial_nibble_sel = 1'b0, test_pattern_sel = 1'b0;
   logic run = 1'b0, feed = 1'b0, fill = 1'b0, took = 1'b0, eund = 1'b0, rdy = 1'b1;
   logic backplane_tx_valid = 1'b0;
   logic [7:0] backplane_tx_in = 8'h00;
   t1_sig_pkg::slot_time_t slot_time;
   logic [7:0] serial_sig_in, line_rx_data, host_rdata, line_tx_data;
   logic [7:0] backplane_rx_out, prbs_det_data;
   logic backplane_tx_ready, line_tx_valid, backplane_rx_valid, prbs_det_valid, tx_underrun;
   logic [7:0] ctrl [24];
   logic [7:0] sig [24];
   logic [3:0] lat [24] = '{default: 4'h0};
   logic [7:0] fifo_q [$];
   logic [7:0] msg = 8'h00, etx, erx, ec, bp, tb, rxs;
   logic [2:0] mwp = 3'h0;
   logic [14:0] plfsr = t1_sig_pkg::PRBS_SEED;
   logic [1:0] pend = 2'h0;
   int n_fail = 0, checked = 0, cyc = 0;

   always #2.5 clock = ~clock;

   t1_tx_signalling_slot_ctrl uut (.clock(clock), .rst_n(rst_n), .host_req(host_req),
      .host_rdata(host_rdata), .esf_mode(esf_mode), .serial_nibble_sel(serial_nibble_sel),
      .test_pattern_sel(test_pattern_sel), .slot_time(slot_time),
      .serial_sig_in(serial_sig_in), .line_rx_data(line_rx_data),
      .backplane_tx_valid(backplane_tx_valid), .backplane_tx_ready(backplane_tx_ready),
      .backplane_tx_in(backplane_tx_in), .line_tx_data(line_tx_data),
      .line_tx_valid(line_tx_valid), .backplane_rx_out(backplane_rx_out),
      .backplane_rx_valid(backplane_rx_valid), .prbs_det_data(prbs_det_data),
      .prbs_det_valid(prbs_det_valid), .tx_underrun(tx_underrun));

   framer_model far_end (.clock(clock), .run(run), .esf_mode(esf_mode),
      .slot_time(slot_time), .serial_sig_in(serial_sig_in), .line_rx_data(line_rx_data));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("Comparisons %0d, errors %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Read data is taken two edges after the request, where it has surely settled
   task automatic host_cycle(input logic w, input logic [3:0] pg, input logic [4:0] ad,
      input logic [7:0] d);
      host_req = '{cs: 1'b1, wr: w, rd: !w, page: pg, addr: ad, wdata: d};
      @(negedge clock);
      host_req = '0;
      @(negedge clock);
   endtask

   task automatic ch_access(input logic w, input logic [3:0] base, input int ch,
      input logic [7:0] d);
      host_cycle(w, base + 4'(ch / 16), 5'h10 + 5'(ch % 16), d);
   endtask

   // Priority: remote loop, test, message, backplane byte; robbed bit replaces the LSB
   function automatic logic [7:0] exp_tx(logic [7:0] c, logic [7:0] rx, logic [7:0] b,
      logic [3:0] s, logic [4:0] f);
      logic [7:0] v;
      v = c[5] ? rx : (c[3] ? tb : (c[7] ? msg : b ^ {8{c[6]}}));
      if (!c[0] && f == t1_sig_pkg::FRAME_A)
         v[0] = s[3];
      if (!c[0] && f == t1_sig_pkg::FRAME_B)
         v[0] = s[2];
      if (!c[0] && esf_mode && f == t1_sig_pkg::FRAME_C)
         v[0] = s[1];
      if (!c[0] && esf_mode && f == t1_sig_pkg::FRAME_D)
         v[0] = s[0];
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_fail++;
         summarize();
      end
      if (slot_time.strobe && rst_n)
      begin
         ec = ctrl[slot_time.slot];
         eund = (fifo_q.size() == 0);
         bp = eund ? t1_sig_pkg::IDLE_BYTE : fifo_q.pop_front();
         if (slot_time.frame == t1_sig_pkg::FRAME_SF_START)
            lat[slot_time.slot] = ec[1] ? sig[slot_time.slot][3:0]
               : (serial_nibble_sel ? serial_sig_in[7:4] : serial_sig_in[3:0]);
         // Milliwatt steps once per frame; PRBS steps only on slots that send it
         tb = test_pattern_sel ? t1_sig_pkg::MW_TABLE[63 - 8 * mwp -: 8] : plfsr[14:7];
         etx = exp_tx(ec, line_rx_data, bp, lat[slot_time.slot], slot_time.frame);
         erx = (ec[2] && test_pattern_sel) ? tb : (ec[4] ? etx : line_rx_data) ^ {8{ec[6]}};
         rxs = line_rx_data;
         mwp = mwp + 3'(slot_time.slot == 5'h00);
         if (ec[3] && !ec[5] && !test_pattern_sel)
            repeat (8) plfsr = {plfsr[13:0], plfsr[14] ^ plfsr[13]};
         pend = 2'h2;
      end
      // Ready as settled before this edge; reading it here would race the FIFO pointers
      took = backplane_tx_valid && rdy && rst_n;
      if (took)
         fifo_q.push_back(backplane_tx_in);
   end

   // Offer is held until accepted; stalls come from the FIFO being full
   always @(negedge clock)
   begin
      rdy = backplane_tx_ready;
      if (!backplane_tx_valid || took)
      begin
         backplane_tx_valid <= fill || (feed && $urandom_range(1, 0) == 1);
         backplane_tx_in <= 8'($urandom);
      end
      if (pend != 2'h0)
         pend = pend - 2'h1;
      if (pend == 2'h1)
      begin
         chk(line_tx_valid, 8'h01);
         chk(tx_underrun, {7'h00, eund});
         chk(prbs_det_valid, {7'h00, ec[2] & ~test_pattern_sel});
         chk(line_tx_data, etx);
         chk(backplane_rx_out, erx);
         chk(backplane_rx_valid, 8'h01);
         chk(prbs_det_data, rxs);
      end
   end

   initial
   begin
      void'($urandom(54));
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      host_cycle(1'b0, t1_sig_pkg::MSG_PAGE, t1_sig_pkg::MSG_ADDR, 8'h00);
      chk(host_rdata, 8'h00);
      chk(backplane_tx_ready, 8'h01);
      fill = 1'b1;
      repeat (12) @(negedge clock);
      chk(backplane_tx_ready, 8'h00);
      chk(8'(fifo_q.size()), 8'h08);
      fill = 1'b0;
      for (int r = 0; r < 6; r++)
      begin
         esf_mode = r[0];
         serial_nibble_sel = 1'($urandom);
         test_pattern_sel = 1'($urandom);
         feed = (r > 1);
         msg = 8'($urandom);
         host_cycle(1'b1, t1_sig_pkg::MSG_PAGE, t1_sig_pkg::MSG_ADDR, msg);
         for (int ch = 0; ch < 24; ch++)
         begin
            ctrl[ch] = (r == 0) ? 8'h00 : 8'($urandom);
            if (r < 2 || $urandom_range(3, 0) != 0)
               ctrl[ch][3:2] = 2'h0;
            sig[ch] = 8'($urandom);
            ch_access(1'b1, t1_sig_pkg::CTRL_PAGE_LO, ch, ctrl[ch]);
            ch_access(1'b1, t1_sig_pkg::SIG_PAGE_LO, ch, sig[ch]);
         end
         // unmapped writes must not alias onto channels 17-24
         host_cycle(1'b1, t1_sig_pkg::SIG_PAGE_HI, 5'h18 + 5'(r), 8'hFF);
         host_cycle(1'b0, t1_sig_pkg::SIG_PAGE_HI, 5'h18 + 5'(r), 8'h00);
         chk(host_rdata, 8'h00);
         host_cycle(1'b1, t1_sig_pkg::CTRL_PAGE_HI, 5'h1F - 5'(r), 8'hFF);
         host_cycle(1'b0, t1_sig_pkg::CTRL_PAGE_HI, 5'h1F - 5'(r), 8'h00);
         chk(host_rdata, 8'h00);
         host_cycle(1'b0, t1_sig_pkg::MSG_PAGE, t1_sig_pkg::MSG_ADDR, 8'h00);
         chk(host_rdata, msg);
         for (int ch = 0; ch < 24; ch++)
         begin
            ch_access(1'b0, t1_sig_pkg::CTRL_PAGE_LO, ch, 8'h00);
            chk(host_rdata, ctrl[ch]);
            ch_access(1'b0, t1_sig_pkg::SIG_PAGE_LO, ch, 8'h00);
            chk(host_rdata, {4'h0, sig[ch][3:0]});
         end
         run = 1'b1;
         repeat (esf_mode ? 3600 : 1800) @(negedge clock);
         run = 1'b0;
         repeat (4) @(negedge clock);
      end
      summarize();
   end
endmodule
